// file: cpu_bus_model.sv
// CPU side of the register port: one-cycle write and read accesses
`timescale 1ns/100ps
module cpu_bus_model
    import multiplier_pkg::*;
(
    input  wire logic        clk,
    output logic      [7:0]  addr,
    output logic      [15:0] wrData,
    output logic             wrStrobe,
    output logic             rdStrobe,
    input  wire logic [15:0] rdData
);
    // Quiet bus from time zero
    initial
    begin
        addr     = 8'h00;
        wrData   = 16'h0000;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr     <= a;
        wrData   <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
        wrData   <= ~d; // Stale data never looks valid
    endtask

    // Read strobe for one cycle, data taken mid next cycle
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr     <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        @(negedge clk);
        d = rdData;
    endtask
endmodule

// file: multiplier_pkg.sv
// Shared offsets, field positions, reset values and carrier types of the multiplier
package multiplier_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // First operand, 16-bit, low word selects the operation
    localparam logic [7:0] OFF_OP1_UMPY      = 8'h00;
    localparam logic [7:0] OFF_OP1_SMPY      = 8'h02;
    localparam logic [7:0] OFF_OP1_UMAC      = 8'h04;
    localparam logic [7:0] OFF_OP1_SMAC      = 8'h06;
    // Second operand, 16-bit, starts the operation
    localparam logic [7:0] OFF_OP2_START     = 8'h08;
    // Compatibility view of the 32-bit result
    localparam logic [7:0] OFF_COMPAT_LOW    = 8'h0A;
    localparam logic [7:0] OFF_COMPAT_HIGH   = 8'h0C;
    localparam logic [7:0] OFF_SUM_EXT       = 8'h0E;
    // First operand, 32-bit pairs
    localparam logic [7:0] OFF_OP1_UMPY_LOW  = 8'h10;
    localparam logic [7:0] OFF_OP1_UMPY_HIGH = 8'h12;
    localparam logic [7:0] OFF_OP1_SMPY_LOW  = 8'h14;
    localparam logic [7:0] OFF_OP1_SMPY_HIGH = 8'h16;
    localparam logic [7:0] OFF_OP1_UMAC_LOW  = 8'h18;
    localparam logic [7:0] OFF_OP1_UMAC_HIGH = 8'h1A;
    localparam logic [7:0] OFF_OP1_SMAC_LOW  = 8'h1C;
    localparam logic [7:0] OFF_OP1_SMAC_HIGH = 8'h1E;
    // Second operand, 32-bit pair
    localparam logic [7:0] OFF_OP2_LOW_START = 8'h20;
    localparam logic [7:0] OFF_OP2_HIGH      = 8'h22;
    // Result words 0..3 at consecutive word offsets
    localparam logic [7:0] OFF_RESULT_WORD0  = 8'h24;
    localparam logic [7:0] OFF_CONTROL0      = 8'h2C;
    // Byte-wide operand entries
    localparam logic [7:0] OFF_OP1_UMPY_BYTE = 8'h30;
    localparam logic [7:0] OFF_OP1_SMPY_BYTE = 8'h32;
    localparam logic [7:0] OFF_OP1_UMAC_BYTE = 8'h34;
    localparam logic [7:0] OFF_OP1_SMAC_BYTE = 8'h36;
    localparam logic [7:0] OFF_OP2_BYTE      = 8'h38;

    // Control register field positions
    localparam int CTL_SAT_BIT   = 0;
    localparam int CTL_FRAC_BIT  = 1;
    localparam int CTL_CARRY_BIT = 2;

    // Values after reset, and the sum-extension words of negative and carry results
    localparam logic [63:0] RESULT_RESET  = 64'h0000_0000_0000_0000;
    localparam logic [15:0] SUM_EXT_RESET = 16'h0000;
    localparam logic [15:0] SUM_EXT_NEG   = 16'hFFFF;
    localparam logic [15:0] SUM_EXT_CARRY = 16'h0001;

    // Operation selected by the first-operand address
    typedef enum logic [3:0] {
        MODE_UMPY = 4'b0001,
        MODE_SMPY = 4'b0010,
        MODE_UMAC = 4'b0100,
        MODE_SMAC = 4'b1000
    } op_mode_t;

    // Operands and widths handed to the arithmetic
    typedef struct packed {
        op_mode_t    mode;
        logic        op1Wide;
        logic        op2Wide;
        logic [31:0] op1;
        logic [31:0] op2;
    } mul_request_t;

    // Stored outcome of one operation
    typedef struct packed {
        logic [63:0] product;
        logic [15:0] sum_extension_word;
        logic        carry;
    } mul_answer_t;

endpackage

// file: multiplier_result_fractional.sv
// Register file, operand capture and result stage of the multiplier
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/100ps
module multiplier_result_fractional
    import multiplier_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
)
(
    input  wire logic          clk,
    input  wire logic          reset_n,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wrData,
    input  wire logic          wrStrobe,
    input  wire logic          rdStrobe,
    output logic      [DW-1:0] rdData
);
    // Operand storage and selection
    op_mode_t    mode;
    logic [31:0] op1;
    logic [31:0] op2;
    logic        op1Wide;
    logic        op2Wide;
    logic        op2LowSeen;
    logic        startPending;

    // Result storage
    logic [63:0] result;
    logic [15:0] sum_extension_word;
    logic        carry;
    logic        fracMode;
    logic        satMode;
    logic        lastWide;

    // Arithmetic and read view
    mul_request_t request;
    mul_answer_t  answer;
    logic [63:0]  view;
    logic [15:0]  viewSumExt;
    logic [15:0]  byteExt;
    logic [DW-1:0] next_rdData;

    // Result word addressed this cycle
    logic [2:0] wordIdx;

    // Decoded write strobes
    logic wrOp1Low;
    logic wrOp1High;
    logic wrOp1Byte;
    logic wrOp2;
    logic wrOp2Byte;
    logic wrOp2Low;
    logic wrOp2High;
    logic wrControl;
    op_mode_t wrMode;

    // Index of a result word, or 4 when the address is none
    function automatic logic [2:0] resultIndex(input logic [AW-1:0] a);
        logic [2:0] idx;
        idx = 3'h4;
        if (a == OFF_COMPAT_LOW || a == OFF_RESULT_WORD0)
            idx = 3'h0;
        else if (a == OFF_COMPAT_HIGH || a == OFF_RESULT_WORD0 + 8'h02)
            idx = 3'h1;
        else if (a == OFF_RESULT_WORD0 + 8'h04)
            idx = 3'h2;
        else if (a == OFF_RESULT_WORD0 + 8'h06)
            idx = 3'h3;
        return idx;
    endfunction

    // Operation chosen by a first-operand address
    function automatic op_mode_t modeOf(input logic [AW-1:0] a);
        op_mode_t m;
        m = MODE_UMPY;
        if (a == OFF_OP1_SMPY || a == OFF_OP1_SMPY_LOW || a == OFF_OP1_SMPY_HIGH
            || a == OFF_OP1_SMPY_BYTE)
            m = MODE_SMPY;
        else if (a == OFF_OP1_UMAC || a == OFF_OP1_UMAC_LOW || a == OFF_OP1_UMAC_HIGH
                 || a == OFF_OP1_UMAC_BYTE)
            m = MODE_UMAC;
        else if (a == OFF_OP1_SMAC || a == OFF_OP1_SMAC_LOW || a == OFF_OP1_SMAC_HIGH
                 || a == OFF_OP1_SMAC_BYTE)
            m = MODE_SMAC;
        return m;
    endfunction

    // True for the low word of any 32-bit first operand
    function automatic logic isOp1Low32(input logic [AW-1:0] a);
        return a == OFF_OP1_UMPY_LOW || a == OFF_OP1_SMPY_LOW
               || a == OFF_OP1_UMAC_LOW || a == OFF_OP1_SMAC_LOW;
    endfunction

    // True for the high word of any 32-bit first operand
    function automatic logic isOp1High(input logic [AW-1:0] a);
        return a == OFF_OP1_UMPY_HIGH || a == OFF_OP1_SMPY_HIGH
               || a == OFF_OP1_UMAC_HIGH || a == OFF_OP1_SMAC_HIGH;
    endfunction

    // Result word index, 4 when the address is none
    assign wordIdx = resultIndex(addr);

    // Address decode of write strobes
    always_comb
    begin
        wrOp1Low  = wrStrobe && (addr == OFF_OP1_UMPY || addr == OFF_OP1_SMPY
                    || addr == OFF_OP1_UMAC || addr == OFF_OP1_SMAC
                    || isOp1Low32(addr));
        wrOp1High = wrStrobe && isOp1High(addr);
        wrOp1Byte = wrStrobe && (addr == OFF_OP1_UMPY_BYTE || addr == OFF_OP1_SMPY_BYTE
                    || addr == OFF_OP1_UMAC_BYTE || addr == OFF_OP1_SMAC_BYTE);
        wrOp2     = wrStrobe && addr == OFF_OP2_START;
        wrOp2Byte = wrStrobe && addr == OFF_OP2_BYTE;
        wrOp2Low  = wrStrobe && addr == OFF_OP2_LOW_START;
        wrOp2High = wrStrobe && addr == OFF_OP2_HIGH;
        wrControl = wrStrobe && addr == OFF_CONTROL0;
        wrMode    = modeOf(addr);
    end

    always_comb
    begin
        if (wrOp1Byte)
            byteExt = {{8{(wrMode == MODE_SMPY || wrMode == MODE_SMAC) & wrData[7]}},
                       wrData[7:0]};
        else
            byteExt = {{8{(mode == MODE_SMPY || mode == MODE_SMAC) & wrData[7]}},
                       wrData[7:0]};
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            mode <= MODE_UMPY;
        else if (wrOp1Low || wrOp1Byte)
            mode <= wrMode;
    end

    // First operand and its width
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            op1     <= 32'h0000_0000;
            op1Wide <= 1'b0;
        end
        // A low write falls back to a 16-bit operand
        else if (wrOp1Low)
        begin
            op1[15:0] <= wrData;
            op1Wide   <= 1'b0;
        end
        else if (wrOp1Byte)
        begin
            op1[15:0] <= byteExt;
            op1Wide   <= 1'b0;
        end
        else if (wrOp1High)
        begin
            op1[31:16] <= wrData;
            op1Wide    <= 1'b1;
        end
    end

    // Second operand, its width and the low-word arming
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            op2        <= 32'h0000_0000;
            op2Wide    <= 1'b0;
            op2LowSeen <= 1'b0;
        end
        else if (wrOp2 || wrOp2Byte)
        begin
            op2[15:0]  <= wrOp2 ? wrData : byteExt;
            op2Wide    <= 1'b0;
            op2LowSeen <= 1'b0;
        end
        else if (wrOp2Low)
        begin
            op2[15:0]  <= wrData;
            op2LowSeen <= 1'b1;
        end
        // High word counts only after an armed low word
        else if (wrOp2High && op2LowSeen)
        begin
            op2[31:16] <= wrData;
            op2Wide    <= 1'b1;
            op2LowSeen <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            startPending <= 1'b0;
        else
            startPending <= wrOp2 || wrOp2Byte || (wrOp2High && op2LowSeen);
    end

    assign request = '{mode: mode, op1Wide: op1Wide, op2Wide: op2Wide, op1: op1, op2: op2};

    // Arithmetic on the stored operands and result
    product_accumulate u_arith (
        .req   (request),
        .prior (result),
        .ans   (answer)
    );

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            result <= RESULT_RESET;
        // A start beats a same-cycle word write
        else if (startPending)
            result <= answer.product;
        else if (wrStrobe && wordIdx != 3'h4)
            result[16*wordIdx[1:0] +: 16] <= wrData;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sum_extension_word   <= SUM_EXT_RESET;
            lastWide <= 1'b0;
        end
        else if (startPending)
        begin
            sum_extension_word   <= answer.sum_extension_word;
            lastWide <= op1Wide | op2Wide;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            carry <= 1'b0;
        // A start beats a same-cycle carry write
        else if (startPending)
            carry <= answer.carry;
        else if (wrControl)
            carry <= wrData[CTL_CARRY_BIT];
    end

    // Mode bits of the control register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fracMode <= 1'b0;
            satMode  <= 1'b0;
        end
        else if (wrControl)
        begin
            fracMode <= wrData[CTL_FRAC_BIT];
            satMode  <= wrData[CTL_SAT_BIT];
        end
    end

    read_adjust u_view (
        .result     (result),
        .sum_extension_word     (sum_extension_word),
        .carry      (carry),
        .wide       (lastWide),
        .frac       (fracMode),
        .sat        (satMode),
        .view       (view),
        .viewSumExt (viewSumExt)
    );

    // Read multiplexer; unmapped and write-only addresses read zero
    always_comb
    begin
        next_rdData = '0;
        if (wordIdx != 3'h4)
            next_rdData = view[16*wordIdx[1:0] +: 16];
        else if (addr == OFF_SUM_EXT)
            next_rdData = viewSumExt;
        else if (addr == OFF_CONTROL0)
        begin
            next_rdData[CTL_SAT_BIT]   = satMode;
            next_rdData[CTL_FRAC_BIT]  = fracMode;
            next_rdData[CTL_CARRY_BIT] = carry;
        end
        else if (isOp1Low32(addr))
            next_rdData = op1[15:0];
        else if (isOp1High(addr))
            next_rdData = op1[31:16];
        else if (addr == OFF_OP2_LOW_START)
            next_rdData = op2[15:0];
        else if (addr == OFF_OP2_HIGH)
            next_rdData = op2[31:16];
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdData <= '0;
        else if (rdStrobe)
            rdData <= next_rdData;
        else
            rdData <= '0;
    end
endmodule

// file: multiplier_result_fractional_assertions.sv
// Port-level assertions for the multiplier result stage
`timescale 1ns/100ps
module multiplier_result_fractional_assertions
    import multiplier_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
)
(
    input wire logic          clk,
    input wire logic          reset_n,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wrData,
    input wire logic          wrStrobe,
    input wire logic          rdStrobe,
    input wire logic [DW-1:0] rdData
);
    logic [1:0] selOp;
    logic [1:0] doneOp;
    logic       wrSeen;
    logic       fracOn;
    logic       satOn;
    logic       isOp1;
    logic       isStart;
    logic       sumRd;
    logic       wideOp1;

    // Decode operand writes and sum-extension reads
    always_comb
    begin
        wideOp1 = addr >= 8'h10 && addr <= 8'h1E;
        isOp1   = wrStrobe && !addr[0] && (addr <= 8'h06 || (wideOp1 && !addr[1])
                  || (addr >= 8'h30 && addr <= 8'h36));
        isStart = wrStrobe && (addr == OFF_OP2_START || addr == OFF_OP2_HIGH || addr == OFF_OP2_BYTE);
        sumRd   = rdStrobe && addr == OFF_SUM_EXT && !fracOn;
    end

    // Last selected and started operation, mode bits
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            selOp  <= 2'd0;
            doneOp <= 2'd0;
            wrSeen <= 1'b0;
            fracOn <= 1'b0;
            satOn  <= 1'b0;
        end
        else
        begin
            if (isOp1)
                selOp <= wideOp1 ? addr[3:2] : addr[2:1];
            if (isStart)
                doneOp <= selOp;
            if (wrStrobe)
                wrSeen <= 1'b1;
            if (wrStrobe && addr == OFF_CONTROL0)
            begin
                fracOn <= wrData[CTL_FRAC_BIT];
                satOn  <= wrData[CTL_SAT_BIT];
            end
        end
    end

    property p_idle_zero;
        @(posedge clk) disable iff (!reset_n) !rdStrobe |=> rdData == '0;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data not zero when idle");

    property p_reset_clear;
        @(posedge clk) disable iff (!reset_n)
        rdStrobe && !wrSeen && ((addr >= OFF_COMPAT_LOW && addr <= OFF_SUM_EXT)
        || (addr >= OFF_RESULT_WORD0 && addr <= OFF_CONTROL0)) |=> rdData == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("result not clear after reset");

    property p_compat_alias;
        @(posedge clk) disable iff (!reset_n)
        (wrStrobe && addr == OFF_RESULT_WORD0 && !fracOn && !satOn)
        ##2 (rdStrobe && addr == OFF_COMPAT_LOW) |=> rdData == $past(wrData, 3);
    endproperty
    a_compat_alias: assert property (p_compat_alias) else $error("compat low differs from word0");

    property p_umpy_sum;
        @(posedge clk) disable iff (!reset_n)
        sumRd && doneOp == 2'd0 |=> rdData == SUM_EXT_RESET;
    endproperty
    a_umpy_sum: assert property (p_umpy_sum) else $error("unsigned multiply sum-ext not zero");

    property p_smpy_sum;
        @(posedge clk) disable iff (!reset_n)
        sumRd && doneOp == 2'd1 |=> rdData == SUM_EXT_NEG || rdData == SUM_EXT_RESET;
    endproperty
    a_smpy_sum: assert property (p_smpy_sum) else $error("signed multiply sum-ext bad");

    property p_umac_sum;
        @(posedge clk) disable iff (!reset_n)
        sumRd && doneOp == 2'd2 |=> rdData == SUM_EXT_CARRY || rdData == SUM_EXT_RESET;
    endproperty
    a_umac_sum: assert property (p_umac_sum) else $error("unsigned accumulate sum-ext bad");

    property p_smac_sum;
        @(posedge clk) disable iff (!reset_n)
        sumRd && doneOp == 2'd3 |=> rdData == SUM_EXT_NEG || rdData == SUM_EXT_RESET;
    endproperty
    a_smac_sum: assert property (p_smac_sum) else $error("signed accumulate sum-ext bad");

    property p_unmapped;
        @(posedge clk) disable iff (!reset_n)
        rdStrobe && addr == 8'h3A |=> rdData == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

bind multiplier_result_fractional multiplier_result_fractional_assertions #(.AW(AW), .DW(DW)) chk
(
    .clk      (clk),
    .reset_n  (reset_n),
    .addr     (addr),
    .wrData   (wrData),
    .wrStrobe (wrStrobe),
    .rdStrobe (rdStrobe),
    .rdData   (rdData)
);

// file: product_accumulate.sv
// Multiply and accumulate arithmetic with sum-extension and carry
`timescale 1ns/100ps
module product_accumulate
    import multiplier_pkg::*;
(
    input  wire mul_request_t req,
    input  wire logic [63:0]  prior,
    output mul_answer_t       ans
);
    logic               signedOp;
    logic               accum;
    logic               wide;
    logic [31:0]        a;
    logic [31:0]        b;
    logic signed [65:0] full;
    logic [32:0]        sum33;
    logic [64:0]        sum65;
    logic [63:0]        res;
    logic               carry;
    logic               sign;

    assign signedOp = req.mode == MODE_SMPY || req.mode == MODE_SMAC;
    assign accum    = req.mode == MODE_UMAC || req.mode == MODE_SMAC;
    assign wide     = req.op1Wide | req.op2Wide;

    // Narrow operands extend from bit 15 when signed
    assign a = req.op1Wide ? req.op1 : {{16{signedOp & req.op1[15]}}, req.op1[15:0]};
    assign b = req.op2Wide ? req.op2 : {{16{signedOp & req.op2[15]}}, req.op2[15:0]};
    assign full = $signed({signedOp & a[31], a}) * $signed({signedOp & b[31], b});

    assign sum33 = {1'b0, prior[31:0]} + {1'b0, full[31:0]};
    assign sum65 = {1'b0, prior} + {1'b0, full[63:0]};

    always_comb
    begin
        if (wide)
        begin
            res   = accum ? sum65[63:0] : full[63:0];
            carry = sum65[64];
            sign  = res[63];
        end
        else
        begin
            res[31:0]  = accum ? sum33[31:0] : full[31:0];
            res[63:32] = {32{signedOp & res[31]}};
            carry      = sum33[32];
            sign       = res[31];
        end
    end

    // carry acts as extra top bit
    always_comb
    begin
        ans.product = res;
        ans.sum_extension_word  = SUM_EXT_RESET;
        ans.carry   = 1'b0;
        unique case (req.mode)
            MODE_UMPY:
            begin
                ans.sum_extension_word = SUM_EXT_RESET;
                ans.carry  = 1'b0;
            end
            MODE_SMPY:
            begin
                ans.sum_extension_word = sign ? SUM_EXT_NEG : SUM_EXT_RESET;
                ans.carry  = sign;
            end
            MODE_UMAC:
            begin
                ans.sum_extension_word = carry ? SUM_EXT_CARRY : SUM_EXT_RESET;
                ans.carry  = carry;
            end
            MODE_SMAC:
            begin
                ans.sum_extension_word = sign ? SUM_EXT_NEG : SUM_EXT_RESET;
                ans.carry  = carry;
            end
        endcase
    end
endmodule

// file: read_adjust.sv
// Read-time view of the result: saturation then fractional shift
`timescale 1ns/100ps
module read_adjust
    import multiplier_pkg::*;
(
    input  wire logic [63:0] result,
    input  wire logic [15:0] sum_extension_word,
    input  wire logic        carry,
    input  wire logic        wide,
    input  wire logic        frac,
    input  wire logic        sat,
    output logic      [63:0] view,
    output logic      [15:0] viewSumExt
);
    logic [63:0] clipped;
    logic        msb;
    logic        nextMsb;

    assign msb     = wide ? result[63] : result[31];
    assign nextMsb = wide ? result[62] : result[30];

    // saturate on carry and sign mismatch
    always_comb
    begin
        clipped = result;
        if (sat && (carry != msb || (frac && msb != nextMsb)))
        begin
            if (wide)
                clipped = (carry != msb ? carry : msb) ? 64'h8000_0000_0000_0000
                                                       : 64'h7FFF_FFFF_FFFF_FFFF;
            else
                clipped[31:0] = (carry != msb ? carry : msb) ? 32'h8000_0000
                                                             : 32'h7FFF_FFFF;
        end
    end

    assign view = frac ? {clipped[62:0], 1'b0} : clipped;

    always_comb
    begin
        if (!frac)
            viewSumExt = sum_extension_word;
        else if (wide)
            viewSumExt = {{15{sum_extension_word[0]}}, result[63]};
        else
            viewSumExt = {{15{result[32]}}, result[31]};
    end
endmodule

// file: tb_multiplier_result_fractional.sv
// Self-checking bench for the multiplier result stage
`timescale 1ns/100ps
module tb_multiplier_result_fractional
    import multiplier_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  addr;
    logic [15:0] wrData;
    logic        wrStrobe;
    logic        rdStrobe;
    logic [15:0] rdData;
    int          n_mismatch = 0;
    int          comparisons = 0;

    // 20 MHz clock
    always #25 clk = ~clk;

    cpu_bus_model cpu (.clk(clk), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData));
    multiplier_result_fractional uut (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData));

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Read one register and compare
    task automatic chk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] got;
        cpu.rd(a, got);
        comparisons++;
        if (got !== e)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t addr %h got %h expected %h", $time, a, got, e);
        end
    endtask

    // Compare all four result words, low first
    task automatic chkRes(input logic [63:0] e);
        for (int i = 0; i < 4; i++)
            chk(OFF_RESULT_WORD0 + 8'(2 * i), e[16*i +: 16]);
    endtask

    // Preload the 64-bit result, low word first
    task automatic preload(input logic [63:0] v);
        for (int i = 0; i < 4; i++)
            cpu.wr(OFF_RESULT_WORD0 + 8'(2 * i), v[16*i +: 16]);
    endtask

    // Hang guard
    initial
    begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        chkRes(RESULT_RESET);
        chk(OFF_SUM_EXT, SUM_EXT_RESET);
        chk(OFF_CONTROL0, 16'h0000);
        chk(8'h3A, 16'h0000);
        $display("test reset done");

        cpu.wr(OFF_OP1_UMPY, 16'h1234);
        cpu.wr(OFF_OP2_START, 16'h5678);
        chkRes(64'h0000_0000_0626_0060);
        chk(OFF_COMPAT_LOW, 16'h0060);
        chk(OFF_COMPAT_HIGH, 16'h0626);
        chk(OFF_SUM_EXT, SUM_EXT_RESET);
        chk(OFF_CONTROL0, 16'h0000);
        $display("test unsigned multiply done");

        cpu.wr(OFF_OP1_SMPY, 16'h8000);
        cpu.wr(OFF_OP2_START, 16'h0003);
        chkRes(64'hFFFF_FFFF_FFFE_8000);
        chk(OFF_SUM_EXT, SUM_EXT_NEG);
        chk(OFF_CONTROL0, 16'h0004);
        $display("test signed multiply done");

        preload(64'h0000_0000_FFFF_FFFF);
        cpu.wr(OFF_RESULT_WORD0, 16'hABCD);
        chk(OFF_COMPAT_LOW, 16'hABCD);
        cpu.wr(OFF_RESULT_WORD0, 16'hFFFF);
        cpu.wr(OFF_OP1_UMAC, 16'h0001);
        cpu.wr(OFF_OP2_START, 16'h0001);
        chkRes(64'h0);
        chk(OFF_SUM_EXT, SUM_EXT_CARRY);
        chk(OFF_CONTROL0, 16'h0004);
        cpu.wr(OFF_OP2_START, 16'h0001);
        chkRes(64'h1);
        chk(OFF_SUM_EXT, SUM_EXT_RESET);
        chk(OFF_CONTROL0, 16'h0000);
        $display("test unsigned accumulate done");

        preload(64'h0000_0000_7FFF_FFFF);
        cpu.wr(OFF_OP1_SMAC, 16'h0001);
        cpu.wr(OFF_OP2_START, 16'h0001);
        chkRes(64'hFFFF_FFFF_8000_0000);
        chk(OFF_SUM_EXT, SUM_EXT_NEG);
        chk(OFF_CONTROL0, 16'h0000);
        $display("test signed accumulate overflow done");

        cpu.wr(OFF_OP1_SMPY_BYTE, 16'h0080);
        cpu.wr(OFF_OP2_BYTE, 16'h0002);
        chkRes(64'hFFFF_FFFF_FFFF_FF00);
        chk(OFF_SUM_EXT, SUM_EXT_NEG);
        $display("test signed bytes done");

        cpu.wr(OFF_OP1_SMPY_LOW, 16'h0001);
        cpu.wr(OFF_OP1_SMPY_HIGH, 16'h8000);
        cpu.wr(OFF_OP2_LOW_START, 16'h0002);
        cpu.wr(OFF_OP2_HIGH, 16'h0000);
        chkRes(64'hFFFF_FFFF_0000_0002);
        chk(OFF_CONTROL0, 16'h0004);
        $display("test wide signed multiply done");

        cpu.wr(OFF_CONTROL0, 16'h0002);
        cpu.wr(OFF_OP1_SMPY, 16'hC000);
        cpu.wr(OFF_OP2_START, 16'h4000);
        chk(OFF_RESULT_WORD0 + 8'h02, 16'hE000);
        chk(OFF_SUM_EXT, SUM_EXT_NEG);
        chk(OFF_CONTROL0, 16'h0006);
        cpu.wr(OFF_CONTROL0, 16'h0000);
        chk(OFF_RESULT_WORD0 + 8'h02, 16'hF000);
        // Q31 by Q31 in fractional mode
        cpu.wr(OFF_CONTROL0, 16'h0002);
        cpu.wr(OFF_OP1_SMPY_LOW, 16'h0000);
        cpu.wr(OFF_OP1_SMPY_HIGH, 16'hC000);
        cpu.wr(OFF_OP2_LOW_START, 16'h0000);
        cpu.wr(OFF_OP2_HIGH, 16'h4000);
        chkRes(64'hE000_0000_0000_0000);
        chk(OFF_SUM_EXT, SUM_EXT_NEG);
        chk(OFF_CONTROL0, 16'h0006);
        cpu.wr(OFF_CONTROL0, 16'h0000);
        chk(OFF_RESULT_WORD0 + 8'h06, 16'hF000);
        $display("test fractional done");

        // Saturated read of a signed accumulate overflow
        cpu.wr(OFF_CONTROL0, 16'h0001);
        preload(64'h0000_0000_7FFF_FFFF);
        cpu.wr(OFF_OP1_SMAC, 16'h0001);
        cpu.wr(OFF_OP2_START, 16'h0001);
        chkRes(64'hFFFF_FFFF_7FFF_FFFF);
        chk(OFF_SUM_EXT, SUM_EXT_NEG);
        chk(OFF_CONTROL0, 16'h0001);
        cpu.wr(OFF_CONTROL0, 16'h0000);
        chk(OFF_RESULT_WORD0 + 8'h02, 16'h8000);
        $display("test saturation done");
        final_report();
    end
endmodule
